/* hw/dwsr_nv_timer.sv */
// nonvolatile write cycle timer: one done pulse a fixed count after start
`timescale 1ns/1ps
`default_nettype none
module dwsr_nv_timer
  import dwsr_pkg::*;
#(
  parameter logic [NV_TIMER_W-1:0] CYCLES = NV_TIMER_W'(NV_WRITE_CYCLES)
)
(
  input  wire logic mclk,
  input  wire logic rst_n,
  input  wire logic start,
  output logic      done
);

  logic [NV_TIMER_W-1:0] count_reg;
  logic [NV_TIMER_W-1:0] count_next;
  logic                  run_reg;
  logic                  run_next;
  logic                  done_reg;
  logic                  done_next;

  // count up while running; done is registered one cycle ahead, so busy spans exactly CYCLES cycles
  // and the write never runs past its limit
  always_comb
  begin
    count_next = count_reg;
    run_next   = run_reg;
    done_next  = 1'b0;
    if (start)
    begin
      count_next = TIMER_ONE;
      run_next   = 1'b1;
    end
    else if (run_reg)
    begin
      if (count_reg >= CYCLES - TIMER_ONE)
      begin
        run_next  = 1'b0;
        done_next = 1'b1;
      end
      else
      begin
        count_next = count_reg + TIMER_ONE;
      end
    end
  end

  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      count_reg <= TIMER_RST;
      run_reg   <= 1'b0;
      done_reg  <= 1'b0;
    end
    else
    begin
      count_reg <= count_next;
      run_reg   <= run_next;
      done_reg  <= done_next;
    end
  end

  assign done = done_reg;

endmodule
`default_nettype wire

/* hw/dwsr_pkg.sv */
// shared constants and types for the dual wiper setting register bank
package dwsr_pkg;

  // geometry
  localparam int TAP_COUNT   = 2;
  localparam int SLOT_COUNT  = 4;
  localparam int POS_W       = 6;
  localparam int COUNTER_W   = 8;
  localparam int SLOT_W      = 8;
  localparam int SLOT_SEL_W  = 2;
  localparam int SWITCH_COUNT = 64;

  // field layout of the wiper counter: two fixed-zero bits above the position
  localparam int          PAD_W   = COUNTER_W - POS_W;
  localparam logic [PAD_W-1:0] PAD_ZERO = 2'h0;

  // position limits and reset values
  localparam logic [POS_W-1:0]      POS_MIN      = 6'h00;
  localparam logic [POS_W-1:0]      POS_MAX      = 6'h3F;
  localparam logic [POS_W-1:0]      POS_RST      = 6'h00;
  localparam logic [POS_W-1:0]      POS_ONE      = 6'h01;
  localparam logic [SLOT_SEL_W-1:0] SLOT_ZERO    = 2'h0;
  localparam logic [SLOT_W-1:0]     DATA_RST     = 8'h00;
  localparam logic [SWITCH_COUNT-1:0] SWITCH_RST = 64'h0;

  // nonvolatile write time: figure in ms, clock in MHz, cycles derived (rounded down)
  localparam int NV_WRITE_MS     = 10;
  localparam int CLK_MHZ         = 200;
  localparam int NV_WRITE_CYCLES = NV_WRITE_MS * 1000 * CLK_MHZ;
  localparam int NV_TIMER_W      = 22;
  localparam logic [NV_TIMER_W-1:0] TIMER_ONE = 22'h000001;
  localparam logic [NV_TIMER_W-1:0] TIMER_RST = 22'h000000;

  // decoded host commands
  typedef enum logic [3:0] {
    OP_WRITE_COUNTER,
    OP_READ_COUNTER,
    OP_READ_SLOT,
    OP_WRITE_SLOT,
    OP_SLOT_TO_COUNTER,
    OP_COUNTER_TO_SLOT,
    OP_GLOBAL_SLOT_TO_COUNTER,
    OP_GLOBAL_COUNTER_TO_SLOT,
    OP_STEP
  } dwsr_op_t;

endpackage

/* hw/dwsr_tap.sv */
// one tap: volatile wiper position counter with one-hot switch decode
`timescale 1ns/1ps
`default_nettype none
module dwsr_tap
  import dwsr_pkg::*;
(
  input  wire logic                    mclk,
  input  wire logic                    rst_n,
  input  wire logic                    load_en,
  input  wire logic [POS_W-1:0]        load_value,
  input  wire logic                    step_en,
  input  wire logic                    step_up,
  output logic      [POS_W-1:0]        position,
  output logic      [SWITCH_COUNT-1:0] switches
);

  logic [POS_W-1:0]        pos_reg;
  logic [POS_W-1:0]        pos_next;
  logic [SWITCH_COUNT-1:0] switch_reg;
  logic [SWITCH_COUNT-1:0] switch_next;

  // load wins over step; steps saturate instead of wrapping
  always_comb
  begin
    pos_next = pos_reg;
    if (load_en)
    begin
      pos_next = load_value;
    end
    else if (step_en)
    begin
      if (step_up && pos_reg != POS_MAX)
      begin
        pos_next = pos_reg + POS_ONE;
      end
      else if (!step_up && pos_reg != POS_MIN)
      begin
        pos_next = pos_reg - POS_ONE;
      end
    end
  end

  // one-hot decode of the next position, so switches track position cycle for cycle after reset, which opens them all
  genvar gi;
  generate
    for (gi = 0; gi < SWITCH_COUNT; gi = gi + 1)
    begin : g_sw
      always_comb
      begin
        switch_next[gi] = (pos_next == POS_W'(gi));
      end
    end
  endgenerate

  // volatile: reset clears, restore from slot zero follows
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      pos_reg    <= POS_RST;
      switch_reg <= SWITCH_RST;
    end
    else
    begin
      pos_reg    <= pos_next;
      switch_reg <= switch_next;
    end
  end

  assign position = pos_reg;
  assign switches = switch_reg;

endmodule
`default_nettype wire

/* hw/dwsr_top.sv */
// dual wiper setting register bank: counters, stored slots and command decode
//
// Function
// - two separate wiper counters; both taps share one write timer and busy flag.
// - counter value decodes one-hot to close exactly one of 64 switches; reset leaves all open.
// - write-counter command overwrites the chosen tap counter directly.
// - transfer command loads a counter from the selected slot of that tap.
// - step command moves only the selected counter by one; slots untouched.
// - after power-up each counter reloads from its own slot zero.
// - counter contents are volatile and lost on reset.
// - each tap has four nonvolatile slots numbered zero to three.
// - slots readable and writable; copies run both ways with the counter.
// - any slot change is a nonvolatile write lasting up to 10 ms.
// - counter is eight bits, upper two zero, six position bits low.
// - slots hold any host value, not limited to positions.
// - tap-select bit zero picks the first tap, one the second.
// - two-bit slot field picks one of the four slots of that tap.
`timescale 1ns/1ps
`default_nettype none
module dwsr_top
  import dwsr_pkg::*;
#(
  parameter int NV_CYCLES = NV_WRITE_CYCLES
)
(
  input  wire logic                        mclk,
  input  wire logic                        rst_n,
  input  wire logic                        cmd_valid,
  input  wire dwsr_pkg::dwsr_op_t          cmd_op,
  input  wire logic                        tap_select_bit,
  input  wire logic [dwsr_pkg::SLOT_SEL_W-1:0] slot_select_field,
  input  wire logic [dwsr_pkg::SLOT_W-1:0] cmd_data,
  input  wire logic                        cmd_step_up,
  output logic                             cmd_ready,
  output logic                             cmd_refused,
  output logic                             nv_busy,
  output logic                             rd_valid,
  output logic      [dwsr_pkg::SLOT_W-1:0] rd_data,
  output logic      [dwsr_pkg::COUNTER_W-1:0] first_tap_counter,
  output logic      [dwsr_pkg::COUNTER_W-1:0] second_tap_counter,
  output logic      [dwsr_pkg::SWITCH_COUNT-1:0] first_tap_switches,
  output logic      [dwsr_pkg::SWITCH_COUNT-1:0] second_tap_switches
);

  import dwsr_pkg::*;

  typedef enum logic [1:0] {
    ST_RESTORE,
    ST_RUN
  } dwsr_state_t;

  // nonvolatile slots: never reset, so contents survive rst_n like a power cycle
  logic [SLOT_W-1:0] stored_setting_slot [TAP_COUNT][SLOT_COUNT];

  dwsr_state_t            state_reg;
  dwsr_state_t            state_next;
  logic                   ready_reg;
  logic                   ready_next;
  logic                   refused_reg;
  logic                   refused_next;
  logic                   busy_reg;
  logic                   busy_next;
  logic                   rd_valid_reg;
  logic                   rd_valid_next;
  logic [SLOT_W-1:0]      rd_data_reg;
  logic [SLOT_W-1:0]      rd_data_next;
  logic [TAP_COUNT-1:0]   pend_mask_reg;
  logic [TAP_COUNT-1:0]   pend_mask_next;
  logic [SLOT_SEL_W-1:0]  pend_slot_reg;
  logic [SLOT_SEL_W-1:0]  pend_slot_next;
  logic [SLOT_W-1:0]      pend_data_reg [TAP_COUNT];
  logic [SLOT_W-1:0]      pend_data_next [TAP_COUNT];

  logic                   accept;
  logic                   slot_op;
  logic                   nv_start;
  logic                   nv_done;
  logic [TAP_COUNT-1:0]   load_en;
  logic [POS_W-1:0]       load_value [TAP_COUNT];
  logic [TAP_COUNT-1:0]   step_en;
  logic [POS_W-1:0]       position [TAP_COUNT];
  logic [SWITCH_COUNT-1:0] switches [TAP_COUNT];
  logic                   tsel;

  assign tsel = tap_select_bit;
  assign accept = cmd_valid && ready_reg;

  // ops that change a slot take the nonvolatile path
  always_comb
  begin
    slot_op = (cmd_op == OP_WRITE_SLOT) || (cmd_op == OP_COUNTER_TO_SLOT)
           || (cmd_op == OP_GLOBAL_COUNTER_TO_SLOT);
  end

  // one counter per tap, fully independent
  genvar gt;
  generate
    for (gt = 0; gt < TAP_COUNT; gt = gt + 1)
    begin : g_tap
      dwsr_tap u_tap (
        .mclk       (mclk),
        .rst_n      (rst_n),
        .load_en    (load_en[gt]),
        .load_value (load_value[gt]),
        .step_en    (step_en[gt]),
        .step_up    (cmd_step_up),
        .position   (position[gt]),
        .switches   (switches[gt])
      );
    end
  endgenerate

  dwsr_nv_timer #(
    .CYCLES (NV_TIMER_W'(NV_CYCLES))
  ) u_nv_timer (
    .mclk  (mclk),
    .rst_n (rst_n),
    .start (nv_start),
    .done  (nv_done)
  );

  // command decode, counter control and pending slot write capture
  always_comb
  begin
    state_next     = state_reg;
    ready_next     = ready_reg;
    refused_next   = 1'b0;
    busy_next      = busy_reg;
    rd_valid_next  = 1'b0;
    rd_data_next   = rd_data_reg;
    pend_mask_next = pend_mask_reg;
    pend_slot_next = pend_slot_reg;
    nv_start       = 1'b0;
    load_en        = '0;
    step_en        = '0;
    for (int t = 0; t < TAP_COUNT; t++)
    begin
      load_value[t]     = POS_RST;
      pend_data_next[t] = pend_data_reg[t];
    end
    if (nv_done)
    begin
      busy_next      = 1'b0;
      pend_mask_next = '0;
    end
    unique case (state_reg)
      ST_RESTORE:
      begin
        // counters take slot zero, whatever they held before
        for (int t = 0; t < TAP_COUNT; t++)
        begin
          load_en[t]    = 1'b1;
          load_value[t] = stored_setting_slot[t][SLOT_ZERO][POS_W-1:0];
        end
        state_next = ST_RUN;
        ready_next = 1'b1;
      end
      ST_RUN:
      begin
        if (accept && slot_op && busy_reg)
        begin
          refused_next = 1'b1;
        end
        else if (accept)
        begin
          unique case (cmd_op)
            OP_WRITE_COUNTER:
            begin
              load_en[tsel]    = 1'b1;
              load_value[tsel] = cmd_data[POS_W-1:0];
            end
            OP_READ_COUNTER:
            begin
              rd_valid_next = 1'b1;
              rd_data_next  = {PAD_ZERO, position[tsel]};
            end
            OP_READ_SLOT:
            begin
              rd_valid_next = 1'b1;
              rd_data_next  = stored_setting_slot[tsel][slot_select_field];
            end
            OP_WRITE_SLOT:
            begin
              nv_start             = 1'b1;
              busy_next            = 1'b1;
              pend_mask_next       = '0;
              pend_mask_next[tsel] = 1'b1;
              pend_slot_next       = slot_select_field;
              pend_data_next[tsel] = cmd_data;
            end
            OP_SLOT_TO_COUNTER:
            begin
              load_en[tsel]    = 1'b1;
              load_value[tsel] = stored_setting_slot[tsel][slot_select_field][POS_W-1:0];
            end
            OP_COUNTER_TO_SLOT:
            begin
              nv_start             = 1'b1;
              busy_next            = 1'b1;
              pend_mask_next       = '0;
              pend_mask_next[tsel] = 1'b1;
              pend_slot_next       = slot_select_field;
              pend_data_next[tsel] = {PAD_ZERO, position[tsel]};
            end
            OP_GLOBAL_SLOT_TO_COUNTER:
            begin
              for (int t = 0; t < TAP_COUNT; t++)
              begin
                load_en[t]    = 1'b1;
                load_value[t] = stored_setting_slot[t][slot_select_field][POS_W-1:0];
              end
            end
            OP_GLOBAL_COUNTER_TO_SLOT:
            begin
              // both taps share one write cycle
              nv_start       = 1'b1;
              busy_next      = 1'b1;
              pend_mask_next = '1;
              pend_slot_next = slot_select_field;
              for (int t = 0; t < TAP_COUNT; t++)
              begin
                pend_data_next[t] = {PAD_ZERO, position[t]};
              end
            end
            OP_STEP:
            begin
              step_en[tsel] = 1'b1;
            end
            default:
            begin
              refused_next = 1'b1;   // unknown op code
            end
          endcase
        end
      end
    endcase
  end

  // control registers
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      state_reg     <= ST_RESTORE;
      ready_reg     <= 1'b0;
      refused_reg   <= 1'b0;
      busy_reg      <= 1'b0;
      rd_valid_reg  <= 1'b0;
      rd_data_reg   <= DATA_RST;
      pend_mask_reg <= '0;
      pend_slot_reg <= SLOT_ZERO;
      for (int t = 0; t < TAP_COUNT; t++)
      begin
        pend_data_reg[t] <= DATA_RST;
      end
    end
    else
    begin
      state_reg     <= state_next;
      ready_reg     <= ready_next;
      refused_reg   <= refused_next;
      busy_reg      <= busy_next;
      rd_valid_reg  <= rd_valid_next;
      rd_data_reg   <= rd_data_next;
      pend_mask_reg <= pend_mask_next;
      pend_slot_reg <= pend_slot_next;
      for (int t = 0; t < TAP_COUNT; t++)
      begin
        pend_data_reg[t] <= pend_data_next[t];
      end
    end
  end

  // slot contents change only when the write cycle completes; a read before then sees old data
  always_ff @(posedge mclk)
  begin
    for (int t = 0; t < TAP_COUNT; t++)
    begin
      if (rst_n && nv_done && pend_mask_reg[t])
      begin
        stored_setting_slot[t][pend_slot_reg] <= pend_data_reg[t];
      end
    end
  end

  assign cmd_ready           = ready_reg;
  assign cmd_refused         = refused_reg;
  assign nv_busy             = busy_reg;
  assign rd_valid            = rd_valid_reg;
  assign rd_data             = rd_data_reg;
  assign first_tap_counter   = {PAD_ZERO, position[0]};   // pad bits constant
  assign second_tap_counter  = {PAD_ZERO, position[1]};
  assign first_tap_switches  = switches[0];
  assign second_tap_switches = switches[1];

endmodule
`default_nettype wire

/* testbench/dwsr_host.sv */
// host controller model driving the decoded command port
`timescale 1ns/1ps
`default_nettype none
module dwsr_host
  import dwsr_pkg::*;
(
  input  wire logic               mclk,
  input  wire logic               cmd_ready,
  input  wire logic               nv_busy,
  output var  logic               cmd_valid,
  output var  dwsr_pkg::dwsr_op_t cmd_op,
  output var  logic               tap_select_bit,
  output var  logic [1:0]         slot_select_field,
  output var  logic [7:0]         cmd_data,
  output var  logic               cmd_step_up
);
  // quiet bus at time zero
  initial
  begin
    cmd_valid = 1'h0;
    cmd_op = OP_READ_COUNTER;
    tap_select_bit = 1'h0;
    slot_select_field = 2'h0;
    cmd_data = 8'h00;
    cmd_step_up = 1'h0;
  end

  // present a command; held until an edge samples ready high, giving up after 8 edges
  task automatic send(input dwsr_op_t op, input logic tap, input logic [1:0] slot,
                      input logic [7:0] d, input logic up, output bit ok);
    int n;
    cmd_valid <= 1'h1;
    cmd_op <= op;
    tap_select_bit <= tap;
    slot_select_field <= slot;
    cmd_data <= d;
    cmd_step_up <= up;
    ok = 1'b0;
    for (n = 0; n < 8 && !ok; n++)
    begin
      @(posedge mclk);
      ok = cmd_ready;
    end
  endtask

  // release: data, tap and slot fields flip so stale values never look valid
  task automatic idle();
    cmd_valid <= 1'h0;
    cmd_data <= ~cmd_data;
    tap_select_bit <= ~tap_select_bit;
    slot_select_field <= ~slot_select_field;
    @(posedge mclk);
  endtask

  // slot data is trusted only once the write cycle ends
  task automatic wait_nv(output bit ok);
    int n;
    ok = 1'b0;
    for (n = 0; n < 64 && !ok; n++)
    begin
      @(posedge mclk);
      ok = !nv_busy;
    end
  endtask
endmodule
`default_nettype wire

/* testbench/dwsr_monitor.sv */
// checker for the dual wiper register bank, bound to its top ports
`timescale 1ns/1ps
`default_nettype none
module dwsr_monitor
  import dwsr_pkg::*;
#(
  parameter int NV_CYCLES = 20
)
(
  input wire logic               mclk,
  input wire logic               rst_n,
  input wire logic               cmd_valid,
  input wire dwsr_pkg::dwsr_op_t cmd_op,
  input wire logic               tap_select_bit,
  input wire logic [1:0]         slot_select_field,
  input wire logic [7:0]         cmd_data,
  input wire logic               cmd_step_up,
  input wire logic               cmd_ready,
  input wire logic               cmd_refused,
  input wire logic               nv_busy,
  input wire logic               rd_valid,
  input wire logic [7:0]         rd_data,
  input wire logic [7:0]         first_tap_counter,
  input wire logic [7:0]         second_tap_counter,
  input wire logic [63:0]        first_tap_switches,
  input wire logic [63:0]        second_tap_switches
);
  logic        take;
  logic        rd_take;
  logic        ld;
  logic        slot_chg;
  logic [5:0]  cur;
  logic [7:0]  oth;
  logic [5:0]  step_n;
  logic [31:0] busy_reg;
  logic [31:0] busy_next;

  // decoded views of the command being taken
  assign take = cmd_valid && cmd_ready;
  assign rd_take = take && (cmd_op == OP_READ_COUNTER || cmd_op == OP_READ_SLOT);
  // counter loads and steps only; decode is not judged before both taps hold known data
  assign ld = take && cmd_op inside {OP_WRITE_COUNTER, OP_STEP, OP_SLOT_TO_COUNTER, OP_GLOBAL_SLOT_TO_COUNTER};
  assign slot_chg = take && cmd_op inside {OP_WRITE_SLOT, OP_COUNTER_TO_SLOT, OP_GLOBAL_COUNTER_TO_SLOT};
  assign cur = tap_select_bit ? second_tap_counter[5:0] : first_tap_counter[5:0];
  assign oth = tap_select_bit ? first_tap_counter : second_tap_counter;
  // saturating step, no wrap at either end
  assign step_n = cmd_step_up ? ((cur == 6'h3F) ? cur : cur + 6'h01) : ((cur == 6'h00) ? cur : cur - 6'h01);

  // length of the current busy stretch
  always_comb
  begin
    busy_next = nv_busy ? busy_reg + 32'h1 : 32'h0;
  end

  always_ff @(posedge mclk)
  begin
    busy_reg <= rst_n ? busy_next : 32'h0;
  end

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_n);

  sequence s_slot_go;
    slot_chg && !nv_busy;
  endsequence
  sequence s_write_runs;
    nv_busy && !cmd_refused;
  endsequence

  // selected tap takes the new position, the other tap keeps its value
  property p_load(logic go, logic [5:0] pos);
    go |=> (($past(tap_select_bit) ? second_tap_counter : first_tap_counter) == {2'h0, $past(pos)})
      && (($past(tap_select_bit) ? first_tap_counter : second_tap_counter) == $past(oth));
  endproperty

  tap_decode_a: assert property (
    ld |=> (first_tap_switches == (64'h1 << first_tap_counter[5:0]))
      && (second_tap_switches == (64'h1 << second_tap_counter[5:0])))
    else $error("switch decode not one-hot at counter position");
  pad_zero_a: assert property (
    ld |=> first_tap_counter[7:6] == 2'h0 && second_tap_counter[7:6] == 2'h0)
    else $error("counter upper bits not zero");
  rd_pulse_a: assert property (rd_valid == $past(rd_take))
    else $error("read valid pulse misplaced");
  rd_counter_a: assert property (
    take && cmd_op == OP_READ_COUNTER |=> rd_data == {2'h0, $past(cur)})
    else $error("counter read returned wrong value");
  wr_counter_a: assert property (p_load(take && cmd_op == OP_WRITE_COUNTER, cmd_data[5:0]))
    else $error("counter write wrong");
  step_sat_a: assert property (p_load(take && cmd_op == OP_STEP, step_n))
    else $error("step result wrong");
  slot_refuse_a: assert property (
    slot_chg && nv_busy |=> cmd_refused && $stable(first_tap_counter) && $stable(second_tap_counter))
    else $error("slot op during write not refused");
  nv_start_a: assert property (s_slot_go |=> s_write_runs)
    else $error("write cycle did not start");
  nv_length_a: assert property ($fell(nv_busy) |-> busy_reg == NV_CYCLES)
    else $error("write cycle length wrong");
endmodule

bind dwsr_top dwsr_monitor #(.NV_CYCLES(NV_CYCLES)) mon (
  .mclk(mclk), .rst_n(rst_n), .cmd_valid(cmd_valid), .cmd_op(cmd_op),
  .tap_select_bit(tap_select_bit), .slot_select_field(slot_select_field),
  .cmd_data(cmd_data), .cmd_step_up(cmd_step_up), .cmd_ready(cmd_ready),
  .cmd_refused(cmd_refused), .nv_busy(nv_busy), .rd_valid(rd_valid), .rd_data(rd_data),
  .first_tap_counter(first_tap_counter), .second_tap_counter(second_tap_counter),
  .first_tap_switches(first_tap_switches), .second_tap_switches(second_tap_switches)
);
`default_nettype wire

/* testbench/tb_dual_wiper_setting_registers.sv */
// self-checking bench for the dual wiper setting register bank
`timescale 1ns/1ps
`default_nettype none
module tb_dual_wiper_setting_registers
  import dwsr_pkg::*;
;
  logic        mclk;
  logic        rst_n;
  logic        cmd_valid;
  dwsr_op_t    cmd_op;
  logic        tap_select_bit;
  logic [1:0]  slot_select_field;
  logic [7:0]  cmd_data;
  logic        cmd_step_up;
  logic        cmd_ready;
  logic        cmd_refused;
  logic        nv_busy;
  logic        rd_valid;
  logic [7:0]  rd_data;
  logic [7:0]  ctr0;
  logic [7:0]  ctr1;
  logic [63:0] sw0;
  logic [63:0] sw1;
  int          miscompares = 0;
  int          n_tests = 0;

  // short write time keeps the run brief
  dwsr_top #(.NV_CYCLES(20)) dut (
    .mclk(mclk), .rst_n(rst_n), .cmd_valid(cmd_valid), .cmd_op(cmd_op),
    .tap_select_bit(tap_select_bit), .slot_select_field(slot_select_field),
    .cmd_data(cmd_data), .cmd_step_up(cmd_step_up), .cmd_ready(cmd_ready),
    .cmd_refused(cmd_refused), .nv_busy(nv_busy), .rd_valid(rd_valid), .rd_data(rd_data),
    .first_tap_counter(ctr0), .second_tap_counter(ctr1),
    .first_tap_switches(sw0), .second_tap_switches(sw1)
  );

  dwsr_host host (
    .mclk(mclk), .cmd_ready(cmd_ready), .nv_busy(nv_busy), .cmd_valid(cmd_valid),
    .cmd_op(cmd_op), .tap_select_bit(tap_select_bit), .slot_select_field(slot_select_field),
    .cmd_data(cmd_data), .cmd_step_up(cmd_step_up)
  );

  // 200 MHz clock
  initial
  begin
    mclk = 1'h0;
    forever #2.5 mclk = ~mclk;
  end

  task automatic stop_test();
    if (miscompares == 0 && n_tests > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] got);
    n_tests++;
    if (got !== exp)
    begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask

  // power-up: 20 cycles low, ends on the restore edge
  task automatic do_reset();
    rst_n <= 1'h0;
    repeat (20) @(posedge mclk);
    rst_n <= 1'h1;
    @(posedge mclk);
  endtask

  // a lost handshake counts as a failure and ends the run
  task automatic cmd(input dwsr_op_t op, input logic tap, input logic [1:0] s = 2'h0,
                     input logic [7:0] d = 8'h00, input logic up = 1'h0);
    bit ok;
    host.send(op, tap, s, d, up, ok);
    if (!ok)
    begin
      chk("taken", 64'h1, 64'h0);
      stop_test();
    end
  endtask

  task automatic op1(input dwsr_op_t op, input logic tap, input logic [1:0] s = 2'h0,
                     input logic [7:0] d = 8'h00, input logic up = 1'h0);
    cmd(op, tap, s, d, up);
    host.idle();
  endtask

  task automatic settle();
    bit ok;
    host.wait_nv(ok);
    if (!ok)
    begin
      chk("nv_done", 64'h1, 64'h0);
      stop_test();
    end
  endtask

  task automatic wr_slot(input logic tap, input logic [1:0] s, input logic [7:0] d);
    op1(OP_WRITE_SLOT, tap, s, d);
    settle();
  endtask

  task automatic rd(input dwsr_op_t op, input logic tap, input logic [1:0] s, input logic [7:0] e);
    op1(op, tap, s);
    chk("rd_valid", 64'h1, rd_valid);
    chk("rd_data", e, rd_data);
  endtask

  task automatic cnt_chk(input logic [7:0] e0, input logic [7:0] e1);
    chk("first_tap_counter", e0, ctr0);
    chk("second_tap_counter", e1, ctr1);
  endtask

  // main sequence: slots first, then power cycle and counter operations
  initial
  begin
    do_reset();
    cmd(OP_WRITE_SLOT, 1'h0, 2'h0, 8'hE5);
    cmd(OP_WRITE_SLOT, 1'h1, 2'h0, 8'h1A);
    host.idle();
    chk("cmd_refused", 64'h1, cmd_refused);
    chk("nv_busy", 64'h1, nv_busy);
    settle();
    wr_slot(1'h1, 2'h0, 8'h1A);
    wr_slot(1'h0, 2'h3, 8'hD7);
    wr_slot(1'h1, 2'h3, 8'hFF);
    rd(OP_READ_SLOT, 1'h0, 2'h0, 8'hE5);
    rd(OP_READ_SLOT, 1'h1, 2'h3, 8'hFF);
    rd(OP_READ_SLOT, 1'h1, 2'h0, 8'h1A);
    op1(OP_GLOBAL_SLOT_TO_COUNTER, 1'h0, 2'h0);
    cnt_chk(8'h25, 8'h1A);
    op1(OP_WRITE_COUNTER, 1'h0, 2'h0, 8'h3C);
    cnt_chk(8'h3C, 8'h1A);
    do_reset();
    @(posedge mclk);
    cnt_chk(8'h25, 8'h1A);
    chk("sw0", 64'h1 << 6'h25, sw0);
    chk("sw1", 64'h1 << 6'h1A, sw1);
    op1(OP_WRITE_COUNTER, 1'h0, 2'h0, 8'hFF);
    op1(OP_STEP, 1'h0, 2'h0, 8'h00, 1'h1);
    cnt_chk(8'h3F, 8'h1A);
    op1(OP_STEP, 1'h1);
    rd(OP_READ_COUNTER, 1'h1, 2'h0, 8'h19);
    op1(OP_WRITE_COUNTER, 1'h1, 2'h0, 8'h40);
    op1(OP_STEP, 1'h1);
    cnt_chk(8'h3F, 8'h00);
    op1(OP_SLOT_TO_COUNTER, 1'h0, 2'h3);
    cnt_chk(8'h17, 8'h00);
    op1(OP_GLOBAL_SLOT_TO_COUNTER, 1'h0, 2'h3);
    cnt_chk(8'h17, 8'h3F);
    cmd(OP_COUNTER_TO_SLOT, 1'h1, 2'h2);
    op1(OP_STEP, 1'h1);
    chk("cmd_refused", 64'h0, cmd_refused);
    cnt_chk(8'h17, 8'h3E);
    settle();
    rd(OP_READ_SLOT, 1'h1, 2'h2, 8'h3F);
    op1(OP_GLOBAL_COUNTER_TO_SLOT, 1'h0, 2'h1);
    settle();
    rd(OP_READ_SLOT, 1'h0, 2'h1, 8'h17);
    rd(OP_READ_SLOT, 1'h1, 2'h1, 8'h3E);
    stop_test();
  end
endmodule
`default_nettype wire
